/* File: src/scp_serial_config_port.sv */
// serial configuration port with buffered registers and power-down controls
`timescale 1ns/100ps
module scp_serial_config_port #(
    parameter int TOP_ADDR = 562
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // serial link
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    output logic separate_read_out_pin,
    output logic separate_read_out_pin_oe,
    // chip controls
    input wire logic sleep_request_n,
    input wire logic cpEvent,
    // power-down and alignment outputs
    output logic pllOff,
    output logic vcoOff,
    output logic clkBufOff,
    output logic dividersOff,
    output logic diffOutsOff,
    output logic hsSafeOff,
    output logic distOff,
    output logic alignReq
);
    logic [1:0] rstSync_r;
    logic rstInt_n;
    logic [7:0] shadow [0:TOP_ADDR];
    logic [7:0] active [0:TOP_ADDR];
    logic sclkPrev_r, csPrev_r;
    logic sclkRise, sclkFall, csRise;
    scp_pkg::scp_state_type state_r;
    logic [2:0] bitCnt_r;
    logic instrHi_r, isRead_r, stream_r;
    logic [1:0] left_r;
    logic [9:0] addr_r, addrStep;
    logic [15:0] shift_r, shNxt;
    logic lsbFirst, sepMode, softRst, rdSel, byteDone, wrStb, updReq_r, inRange, rdOn;
    logic [7:0] wrByte, rdByte;
    logic [2:0] rdPos;
    logic [1:0] pllMode;
    logic outBit_r, sdioOe_r, sepOe_r, sepOut_r, started_r;
    logic pllOff_r, vcoOff_r, clkBufOff_r, divOff_r, diffOff_r, hsSafeOff_r, distOff_r;
    logic alignReq_r;

    // release of the outside reset is retimed; assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rstSync_r <= 2'b00;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstInt_n = rstSync_r[1];

    assign lsbFirst = shadow[scp_pkg::ADDR_CFG][scp_pkg::CFG_LSB_BIT];
    assign sepMode = shadow[scp_pkg::ADDR_CFG][scp_pkg::CFG_SEP_OUT_BIT];
    assign softRst = shadow[scp_pkg::ADDR_CFG][scp_pkg::CFG_SRST_LO_BIT]
        & shadow[scp_pkg::ADDR_CFG][scp_pkg::CFG_SRST_HI_BIT];
    assign rdSel = active[scp_pkg::ADDR_READBACK][scp_pkg::READBACK_BIT];
    assign sclkRise = ~csN & sclk & ~sclkPrev_r;
    assign sclkFall = ~csN & ~sclk & sclkPrev_r;
    assign csRise = csN & ~csPrev_r;
    assign shNxt = lsbFirst ? {sdioIn, shift_r[15:1]} : {shift_r[14:0], sdioIn};
    assign byteDone = sclkRise && bitCnt_r == 3'd7 && state_r != scp_pkg::PS_END;
    assign inRange = addr_r <= 10'(TOP_ADDR);
    assign wrStb = byteDone && state_r == scp_pkg::PS_DATA && !isRead_r && inRange;
    assign wrByte = lsbFirst ? shNxt[15:8] : shNxt[7:0];
    // no address is skipped; MSB-first wraps from zero to the top
    assign addrStep = lsbFirst ? addr_r + 10'd1
        : (addr_r == 10'd0 ? 10'(TOP_ADDR) : addr_r - 10'd1);
    assign rdByte = !inRange ? 8'h00 : (rdSel ? active[addr_r] : shadow[addr_r]);
    assign rdPos = lsbFirst ? bitCnt_r : 3'd7 - bitCnt_r;
    assign rdOn = ~csN && state_r == scp_pkg::PS_DATA && isRead_r;
    assign pllMode = active[scp_pkg::ADDR_PLL_OFF][1:0];

    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            sclkPrev_r <= 1'b0;
            csPrev_r <= 1'b1;
        end
        else if (ce)
        begin
            sclkPrev_r <= sclk;
            csPrev_r <= csN;
        end
    end

    // port sequencer
    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            state_r <= scp_pkg::PS_INSTR;
            bitCnt_r <= 3'd0;
            instrHi_r <= 1'b0;
            isRead_r <= 1'b0;
            stream_r <= 1'b0;
            left_r <= 2'd0;
            addr_r <= 10'd0;
            shift_r <= 16'h0000;
        end
        else if (ce)
        begin
            if (csRise)
            begin
                // stall only on a byte boundary of the instruction phase or of a bounded transfer's data phase
                if (bitCnt_r != 3'd0 || state_r == scp_pkg::PS_END
                    || (state_r == scp_pkg::PS_DATA && stream_r))
                begin
                    state_r <= scp_pkg::PS_INSTR;
                    bitCnt_r <= 3'd0;
                    instrHi_r <= 1'b0;
                end
            end
            else if (sclkRise && state_r != scp_pkg::PS_END)
            begin
                shift_r <= shNxt;
                bitCnt_r <= bitCnt_r + 3'd1;
                if (byteDone)
                begin
                    case (state_r)
                        scp_pkg::PS_INSTR:
                        begin
                            if (instrHi_r)
                            begin
                                state_r <= scp_pkg::PS_DATA;
                                isRead_r <= shNxt[15];
                                left_r <= shNxt[14:13];
                                stream_r <= shNxt[14:13] == scp_pkg::LEN_STREAM;
                                addr_r <= shNxt[9:0];
                            end
                            instrHi_r <= 1'b1;
                        end
                        scp_pkg::PS_DATA:
                        begin
                            addr_r <= addrStep;
                            if (stream_r ? addr_r == 10'(TOP_ADDR) : left_r == 2'd0)
                                state_r <= scp_pkg::PS_END;
                            else if (!stream_r)
                                left_r <= left_r - 2'd1;
                        end
                        default:
                            state_r <= scp_pkg::PS_END;
                    endcase
                end
            end
        end
    end

    // shadow buffer; the update bit clears itself one cycle after it is written
    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            for (int i = 0; i <= TOP_ADDR; i++)
                shadow[i] <= (i == 0) ? scp_pkg::CFG_DEFAULT : scp_pkg::REG_DEFAULT;
            updReq_r <= 1'b0;
        end
        else if (ce)
        begin
            if (softRst)
                for (int i = 1; i <= TOP_ADDR; i++)
                    shadow[i] <= scp_pkg::REG_DEFAULT;
            if (updReq_r)
                shadow[TOP_ADDR][scp_pkg::UPDATE_BIT] <= 1'b0;
            if (wrStb)
                shadow[addr_r] <= wrByte;
            updReq_r <= wrStb && addr_r == 10'(TOP_ADDR) && wrByte[scp_pkg::UPDATE_BIT];
        end
    end

    // active image; soft reset overrides a pending update
    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            for (int i = 0; i <= TOP_ADDR; i++)
                active[i] <= (i == 0) ? scp_pkg::CFG_DEFAULT : scp_pkg::REG_DEFAULT;
        end
        else if (ce)
        begin
            if (softRst)
            begin
                for (int i = 1; i <= TOP_ADDR; i++)
                    active[i] <= scp_pkg::REG_DEFAULT;
                active[0] <= shadow[0];
            end
            else if (updReq_r)
            begin
                for (int i = 0; i <= TOP_ADDR; i++)
                    active[i] <= shadow[i];
                // the strobe must never read back as set from the active side
                active[TOP_ADDR][scp_pkg::UPDATE_BIT] <= 1'b0;
            end
        end
    end

    // read launch and pin enables; enables lag chip select by one clock
    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            outBit_r <= 1'b0;
            sepOut_r <= 1'b0;
            sdioOe_r <= 1'b0;
            sepOe_r <= 1'b0;
        end
        else if (ce)
        begin
            if (sclkFall && rdOn)
            begin
                outBit_r <= rdByte[rdPos];
                sepOut_r <= rdByte[rdPos];
            end
            sdioOe_r <= rdOn && !sepMode;
            sepOe_r <= rdOn && sepMode;
        end
    end

    // power-down controls
    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            pllOff_r <= 1'b0;
            vcoOff_r <= 1'b0;
            clkBufOff_r <= 1'b0;
            divOff_r <= 1'b0;
            diffOff_r <= 1'b0;
            hsSafeOff_r <= 1'b0;
            distOff_r <= 1'b0;
        end
        else if (ce)
        begin
            vcoOff_r <= !sleep_request_n;
            clkBufOff_r <= !sleep_request_n;
            divOff_r <= !sleep_request_n;
            diffOff_r <= !sleep_request_n;
            hsSafeOff_r <= !sleep_request_n;
            distOff_r <= !sleep_request_n
                || active[scp_pkg::ADDR_DIST][scp_pkg::DIST_OFF_BIT];
            // sync mode waits on the charge pump to avoid a frequency jump
            if (!sleep_request_n || pllMode == scp_pkg::PLL_OFF_ASYNC)
                pllOff_r <= 1'b1;
            else if (pllMode == scp_pkg::PLL_OFF_SYNC)
            begin
                if (cpEvent)
                    pllOff_r <= 1'b1;
            end
            else
                pllOff_r <= 1'b0;
        end
    end

    // one alignment request after the defaults load
    always_ff @(posedge clk or negedge rstInt_n)
    begin
        if (!rstInt_n)
        begin
            started_r <= 1'b0;
            alignReq_r <= 1'b0;
        end
        else if (ce)
        begin
            started_r <= 1'b1;
            alignReq_r <= !started_r;
        end
    end

    assign sdioOut = outBit_r;
    assign sdioOe = sdioOe_r;
    assign separate_read_out_pin = sepOut_r;
    assign separate_read_out_pin_oe = sepOe_r;
    assign pllOff = pllOff_r;
    assign vcoOff = vcoOff_r;
    assign clkBufOff = clkBufOff_r;
    assign dividersOff = divOff_r;
    assign diffOutsOff = diffOff_r;
    assign hsSafeOff = hsSafeOff_r;
    assign distOff = distOff_r;
    assign alignReq = alignReq_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstInt_n);

    a_cs_float: assert property (ce && csN |=> !sdioOe_r && !sepOe_r)
        else $error("data pin driven with chip select high");
    a_sleep_off: assert property (ce && !sleep_request_n |=> vcoOff_r && divOff_r && pllOff_r)
        else $error("sleep did not shut blocks");
    a_dist_off: assert property (ce && active[scp_pkg::ADDR_DIST][scp_pkg::DIST_OFF_BIT]
        |=> distOff_r)
        else $error("distribution not powered down");
    a_pll_async: assert property (ce && pllMode == scp_pkg::PLL_OFF_ASYNC |=> pllOff_r)
        else $error("async pll power-down late");
    a_upd_copy: assert property (ce && updReq_r && !softRst
        |=> active[scp_pkg::ADDR_PLL_OFF] == $past(shadow[scp_pkg::ADDR_PLL_OFF]))
        else $error("update did not copy buffer");
    a_upd_clear: assert property (ce && updReq_r && !wrStb |=> !shadow[TOP_ADDR][0])
        else $error("update bit not self-cleared");
    a_soft_rst: assert property (ce && softRst |=> active[scp_pkg::ADDR_PLL_OFF] == 8'h00)
        else $error("soft reset kept a value");
    a_abort_port: assert property (ce && csRise && bitCnt_r != 3'd0
        |=> state_r == scp_pkg::PS_INSTR && bitCnt_r == 3'd0 && !instrHi_r)
        else $error("off-boundary select rise not aborted");
    a_stall_hold: assert property (csN && csPrev_r |=> $stable(state_r) && $stable(addr_r))
        else $error("state moved during stall");
    a_align_once: assert property (alignReq_r |=> !alignReq_r)
        else $error("alignment request repeated");

    c_write: cover property (wrStb);
    c_read: cover property (sclkFall && rdOn);
    c_update: cover property (updReq_r);
    c_abort: cover property (csRise && bitCnt_r != 3'd0);
endmodule

/* File: src/scp_pkg.sv */
// constants for the serial configuration port controller
package scp_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] ADDR_CFG = 10'h000;
    localparam logic [9:0] ADDR_READBACK = 10'h004;
    localparam logic [9:0] ADDR_PLL_OFF = 10'h010;
    localparam logic [9:0] ADDR_DIST = 10'h230;
    localparam logic [9:0] ADDR_TOP = 10'h232;
    localparam logic [7:0] CFG_DEFAULT = 8'h18;
    localparam logic [7:0] REG_DEFAULT = 8'h00;
    localparam int CFG_SEP_OUT_BIT = 0;
    localparam int CFG_LSB_BIT = 1;
    localparam int CFG_SRST_LO_BIT = 2;
    localparam int CFG_SRST_HI_BIT = 5;
    localparam int READBACK_BIT = 0;
    localparam int DIST_OFF_BIT = 1;
    localparam int UPDATE_BIT = 0;
    localparam logic [1:0] PLL_OFF_ASYNC = 2'h1;
    localparam logic [1:0] PLL_OFF_SYNC = 2'h3;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    typedef enum logic [1:0] {PS_INSTR, PS_DATA, PS_END} scp_state_type;
endpackage

/* File: sim/scp_host_model.sv */
// host serial master model for the configuration port
`timescale 1ns/100ps
module scp_host_model (
    // system clock
    input wire logic clk,
    // device answers
    input wire logic sdioOut,
    input wire logic sdioOe,
    input wire logic sroPin,
    input wire logic sroOe,
    // serial link
    output logic sclk,
    output logic csN,
    output logic sdioIn
);
    logic hostOe = 1'b1;
    logic hostBit = 1'b0;
    logic sroLine;
    // undriven separate pin reads inverted, so a late enable shows up as bad data
    assign sroLine = sroOe ? sroPin : ~sroPin;
    // released wire shows the inverse of the last bit, never a stale match
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
    end
    task automatic bit_io(input logic b, input logic sep, output logic r);
        hostBit <= b;
        repeat (2) @(posedge clk);
        @(negedge clk);
        r = sep ? sroLine : sdioIn;
        @(posedge clk);
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
        sclk <= 1'b0;
    endtask
    task automatic stall;
        csN <= 1'b1;
        repeat (4) @(posedge clk);
        csN <= 1'b0;
    endtask
    task automatic xfer(input logic rd, input logic [1:0] len, input logic [9:0] addr,
        input int nb, input logic [23:0] wd, input logic sep, input logic lsb, input logic stl,
        output logic [23:0] rdat);
        logic [15:0] instr;
        logic r;
        int k;
        instr = {rd, len, 3'b000, addr};
        rdat = '0;
        @(posedge clk);
        csN <= 1'b0;
        hostOe <= 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            bit_io(instr[lsb ? 15 - i : i], sep, r);
            if (i == 8 && stl)
                stall();
        end
        hostOe <= ~rd;
        for (int i = nb * 8 - 1; i >= 0; i--)
        begin
            // lsb-first keeps byte order but reverses bits inside each byte
            k = lsb ? (i / 8) * 8 + 7 - i % 8 : i;
            bit_io(wd[k], sep, r);
            rdat[k] = r;
            if (i % 8 == 0 && i > 0 && stl)
                stall();
        end
        repeat (2) @(posedge clk);
        csN <= 1'b1;
        hostOe <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // sends a cut-short frame of nbits bits, then raises chip select, on or off a byte boundary
    task automatic cut(input logic [23:0] w, input int nbits);
        logic r;
        @(posedge clk);
        csN <= 1'b0;
        for (int i = 23; i > 23 - nbits; i--)
            bit_io(w[i], 1'b0, r);
        @(posedge clk);
        csN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
module testbench;
    logic clk, rstn, sleepN, cpEvent, sep, lsb;
    logic alignSeen = 1'b0;
    logic csD1 = 1'b1;
    logic csD2 = 1'b1;
    logic ceOn = 1'b1;
    logic sclk, csN, sdioIn, sdioOut, sdioOe, sroPin, sroOe, alignReq;
    logic [6:0] offs;
    logic [23:0] d;
    int fails = 0;
    int compares = 0;
    scp_serial_config_port u_scp_serial_config_port (
        .clk(clk), .rstn(rstn), .ce(ceOn), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .separate_read_out_pin(sroPin),
        .separate_read_out_pin_oe(sroOe), .sleep_request_n(sleepN), .cpEvent(cpEvent),
        .pllOff(offs[6]), .vcoOff(offs[5]), .clkBufOff(offs[4]), .dividersOff(offs[3]),
        .diffOutsOff(offs[2]), .hsSafeOff(offs[1]), .distOff(offs[0]), .alignReq(alignReq)
    );
    scp_host_model u_scp_host_model (
        .clk(clk), .sdioOut(sdioOut), .sdioOe(sdioOe), .sroPin(sroPin), .sroOe(sroOe),
        .sclk(sclk), .csN(csN), .sdioIn(sdioIn)
    );
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xf(input logic rd, input logic [1:0] len, input logic [9:0] a, input int nb,
        input logic [23:0] wd, input logic stl);
        u_scp_host_model.xfer(rd, len, a, nb, wd, sep, lsb, stl, d);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        xf(1'b0, 2'b00, a, 1, {16'h0000, v}, 1'b0);
    endtask
    task automatic upd;
        wr(10'h232, 8'h01);
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rd1(input logic [9:0] a, input logic [7:0] e);
        xf(1'b1, 2'b00, a, 1, 24'h0000_00, 1'b0);
        check(d, {16'h0000, e});
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
        alignSeen <= alignSeen | (alignReq === 1'b1);
    // pins float once chip select has been high for two samples
    always @(negedge clk)
    begin
        csD2 <= csD1;
        csD1 <= csN;
        if (csD1 && csD2 && rstn)
            check({sdioOe, sroOe}, 24'h0000_00);
        if (sep)
            check(sdioOe, 1'b0);
    end
    initial
    begin
        #(20 * 60000);
        fails++;
        wrap_up();
    end
    initial
    begin
        rstn = 1'b0;
        sleepN = 1'b1;
        cpEvent = 1'b0;
        sep = 1'b0;
        lsb = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        check(alignSeen, 1'b1);
        rd1(10'h000, 8'h18);
        xf(1'b0, 2'b10, 10'h012, 3, 24'hA1B2_C3, 1'b1);
        xf(1'b1, 2'b10, 10'h012, 3, 24'h0000_00, 1'b0);
        check(d, 24'hA1B2_C3);
        wr(10'h230, 8'h02);
        check(offs, 7'h00);
        upd();
        check(offs, 7'h01);
        @(posedge clk);
        cpEvent <= 1'b1;
        @(posedge clk);
        cpEvent <= 1'b0;
        repeat (2) @(posedge clk);
        check(offs[6], 1'b1);
        wr(10'h010, 8'h00);
        upd();
        check(offs[6], 1'b0);
        wr(10'h010, 8'h01);
        upd();
        check(offs[6], 1'b1);
        wr(10'h004, 8'h01);
        upd();
        wr(10'h010, 8'h00);
        rd1(10'h010, 8'h01);
        rd1(10'h232, 8'h00);
        xf(1'b1, 2'b11, 10'h001, 3, 24'h0000_00, 1'b0);
        check(d, 24'h0018_00);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        check(offs, 7'h00);
        rd1(10'h012, 8'h00);
        u_scp_host_model.cut({1'b0, 2'b00, 3'b000, 10'h020, 8'hFF}, 20);
        rd1(10'h020, 8'h00);
        u_scp_host_model.cut({1'b0, 2'b00, 3'b000, 10'h020, 8'hFF}, 8);
        u_scp_host_model.cut({1'b0, 2'b00, 3'b000, 10'h020, 8'hFF}, 3);
        wr(10'h020, 8'h5A);
        rd1(10'h020, 8'h5A);
        wr(10'h230, 8'h02);
        upd();
        wr(10'h000, 8'h3C);
        repeat (3) @(posedge clk);
        check(offs[0], 1'b0);
        wr(10'h000, 8'h18);
        rd1(10'h020, 8'h00);
        sep = 1'b1;
        wr(10'h000, 8'h99);
        rd1(10'h000, 8'h99);
        wr(10'h000, 8'h18);
        sep = 1'b0;
        wr(10'h000, 8'h5A);
        lsb = 1'b1;
        xf(1'b0, 2'b01, 10'h030, 2, 24'h00C3_A5, 1'b0);
        xf(1'b1, 2'b01, 10'h030, 2, 24'h0000_00, 1'b0);
        check(d, 24'h00C3_A5);
        rd1(10'h031, 8'hA5);
        wr(10'h000, 8'h18);
        lsb = 1'b0;
        rd1(10'h000, 8'h18);
        @(posedge clk);
        ceOn <= 1'b0;
        sleepN <= 1'b0;
        repeat (3) @(posedge clk);
        check(offs, 7'h00);
        ceOn <= 1'b1;
        repeat (3) @(posedge clk);
        check(offs, 7'h7F);
        wr(10'h020, 8'h66);
        rd1(10'h020, 8'h66);
        wr(10'h230, 8'h02);
        upd();
        check(offs, 7'h7F);
        @(posedge clk);
        sleepN <= 1'b1;
        repeat (3) @(posedge clk);
        check(offs, 7'h01);
        wrap_up();
    end
endmodule
